// ===== hw/swl_consts.svh
// Offsets, field positions and reset values of the shadow word loader
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH

// ****************************************************************
// Register offsets on the plain register port
// ****************************************************************
`define SWL_OFS_MODCFG   4'h0
`define SWL_OFS_BLKPROT  4'h1
`define SWL_OFS_DIVHI    4'h2
`define SWL_OFS_DIVLO    4'h3
`define SWL_OFS_ARRADDR  4'h4
`define SWL_OFS_ARRDATA  4'h5
`define SWL_OFS_STATUS   4'h6

// ****************************************************************
// Shadow word placement and field positions
// ****************************************************************
`define SWL_SHADOW_HI_LOW12 12'hfc0
`define SWL_SHADOW_LO_LOW12 12'hfc1
`define SWL_CFG_DBGLOCK  7
`define SWL_CFG_HIDE     6
`define SWL_PROT_SHADOW  7
`define SWL_CFG_LOADMASK 8'hf0
`define SWL_DIVH_MASK    8'h03

// ****************************************************************
// Reset values
// ****************************************************************
`define SWL_CFG_RST      8'h0c
`define SWL_PROT_RST     8'hff
`define SWL_ERASED_BYTE  8'hff

`endif

// ===== hw/swl_pkg.sv
// Types shared by the shadow word loader files
package swl_pkg;

  // One register port access
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } swl_req_t;

  // Array access presented to the byte memory
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } swl_mem_req_t;

  typedef enum logic [1:0] {
    SWL_LD_HI,
    SWL_LD_LO,
    SWL_LD_DONE
  } swl_load_t;

endpackage

// ===== hw/swl_shadow_mem.sv
// Two-byte nonvolatile shadow word store with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "swl_consts.svh"

module swl_shadow_mem
  import swl_pkg::*;
(
  input  wire logic       clock,    // System clock
  input  wire logic       we,       // Program one byte
  input  wire logic       sel,      // 0 high byte, 1 low byte
  input  wire logic [7:0] wdata,    // Byte to program
  output logic      [7:0] rdata     // Registered read data
);

  logic [7:0] word_q [2];

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Not reset: the word survives system reset like nonvolatile cells
  always_ff @(posedge clock) begin
    if (we) begin
      word_q[sel] <= wdata;
    end
  end

  // Registered read, valid one cycle after sel
  always_ff @(posedge clock) begin
    rdata <= word_q[sel];
  end

  initial begin
    word_q[0] = `SWL_ERASED_BYTE;
    word_q[1] = `SWL_ERASED_BYTE;
  end

endmodule
`default_nettype wire

// ===== hw/swl_array_mem.sv
// Regular nonvolatile byte array with registered read port
`timescale 1ns/1ps
`default_nettype none

module swl_array_mem
  import swl_pkg::*;
#(
  parameter int AW = 12             // Array address width
)(
  input  wire logic          clock, // System clock
  input  wire logic          we,    // Program one byte
  input  wire logic [AW-1:0] addr,  // Byte address
  input  wire logic [7:0]    wdata, // Byte to program
  output logic      [7:0]    rdata  // Registered read data
);

  logic [7:0] mem_q [2**AW];

  // ****************************************************************
  // Storage and read
  // ****************************************************************
  // Contents persist across system reset
  always_ff @(posedge clock) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    rdata <= mem_q[addr];
  end

endmodule
`default_nettype wire

// ===== hw/swl_loader.sv
// Shadow word loader: reset load, shadow mapping and write-once dividers
//
// Contract
// - Shadow word replaces array bytes FC0/FC1 while shadow_hide is zero.
// - After each reset shadow word loads config and both divider registers.
// - High byte: 7 debug lockout, 6 hide, 5:4 test, 1:0 divider high.
// - Low shadow byte loads all eight bits of divider low.
// - Normal mode: only first divider write after reset is accepted.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "swl_consts.svh"

module swl_loader
  import swl_pkg::*;
(
  input  wire logic       clock,          // 100 MHz system clock
  input  wire logic       sys_rst,        // Asynchronous reset, active high
  input  wire logic       special_mode_n, // Low in special mode
  input  wire logic [3:0] reg_addr,       // Register address
  input  wire logic [7:0] reg_wdata,      // Register write data
  input  wire logic       reg_wr,         // Write strobe
  input  wire logic       reg_rd,         // Read strobe
  output logic      [7:0] reg_rdata,      // Read data, cycle after strobe
  output logic            load_done,      // Reset load finished
  output logic            shadow_hide,    // Shadow word hidden
  output logic            debug_lockout_disable, // Debug lockout off
  output logic     [15:0] prog_divider    // Divider high:low
);

  swl_req_t      req;
  swl_mem_req_t  mreq;
  swl_load_t     ld_q;
  logic [7:0]    cfg_q;
  logic [7:0]    prot_q;
  logic [7:0]    divh_q;
  logic [7:0]    divl_q;
  logic [11:0]   aaddr_q;
  logic          div_lock_q;
  logic          rd_arr_q;
  logic [7:0]    rdata_reg_q;
  logic [7:0]    sh_rdata;
  logic [7:0]    ar_rdata;
  logic          sh_sel;
  logic          sh_we;
  logic          ar_we;
  logic          hits_shadow;
  logic          loading;
  logic          div_wr_ok;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign loading = (ld_q != SWL_LD_DONE);

  // True when an array address decodes to the shadow word
  function automatic logic is_shadow(input logic [11:0] a, input logic hide);
    is_shadow = !hide && (a == `SWL_SHADOW_HI_LOW12 || a == `SWL_SHADOW_LO_LOW12);
  endfunction

  // ****************************************************************
  // Array access decode
  // ****************************************************************
  // Shadow word stands in for array bytes FC0 and FC1 while not hidden
  assign hits_shadow = is_shadow(aaddr_q, cfg_q[`SWL_CFG_HIDE]);
  assign mreq = '{we: req.wr && req.addr == `SWL_OFS_ARRDATA && !loading,
                  addr: aaddr_q, wdata: req.wdata};
  // Shadow programming also needs its write protect cleared
  assign sh_we = mreq.we && hits_shadow && !prot_q[`SWL_PROT_SHADOW];
  assign ar_we = mreq.we && !hits_shadow;
  // During load the sequencer owns the shadow read port
  assign sh_sel = loading ? (ld_q == SWL_LD_LO) : aaddr_q[0];

  swl_shadow_mem u_shadow (
    .clock (clock),
    .we    (sh_we),
    .sel   (sh_sel),
    .wdata (mreq.wdata),
    .rdata (sh_rdata)
  );

  swl_array_mem #(.AW(12)) u_array (
    .clock (clock),
    .we    (ar_we),
    .addr  (mreq.addr),
    .wdata (mreq.wdata),
    .rdata (ar_rdata)
  );

  // ****************************************************************
  // Reset load sequencer
  // ****************************************************************
  // High byte read data lands in SWL_LD_LO, low byte in SWL_LD_DONE entry
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ld_q <= SWL_LD_HI;
    end else begin
      unique case (ld_q)
        SWL_LD_HI:   ld_q <= SWL_LD_LO;
        SWL_LD_LO:   ld_q <= SWL_LD_DONE;
        SWL_LD_DONE: ld_q <= SWL_LD_DONE;
      endcase
    end
  end

  // ****************************************************************
  // Module configuration register
  // ****************************************************************
  // Upper nibble loads from shadow; in special mode software may write it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= `SWL_CFG_RST;
    end else if (ld_q == SWL_LD_LO) begin
      cfg_q <= (sh_rdata & `SWL_CFG_LOADMASK) | (cfg_q & ~`SWL_CFG_LOADMASK);
    end else if (req.wr && req.addr == `SWL_OFS_MODCFG) begin
      if (!special_mode_n) begin
        cfg_q <= req.wdata;
      end else begin
        cfg_q <= (cfg_q & `SWL_CFG_LOADMASK) | (req.wdata & ~`SWL_CFG_LOADMASK);
      end
    end
  end

  // Block protect register, shadow protect in bit 7
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prot_q <= `SWL_PROT_RST;
    end else if (req.wr && req.addr == `SWL_OFS_BLKPROT) begin
      prot_q <= req.wdata;
    end
  end

  // ****************************************************************
  // Divider registers with write-once lock
  // ****************************************************************
  // Special mode writes freely; normal mode only until the lock is set
  assign div_wr_ok = !loading && load_done && (!special_mode_n || !div_lock_q);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      divh_q <= 8'h00;
    end else if (ld_q == SWL_LD_LO) begin
      divh_q <= sh_rdata & `SWL_DIVH_MASK;
    end else if (req.wr && req.addr == `SWL_OFS_DIVHI && div_wr_ok) begin
      divh_q <= req.wdata & `SWL_DIVH_MASK;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      divl_q <= 8'h00;
    end else if (ld_q == SWL_LD_DONE && loading == 1'b0 && load_done == 1'b0) begin
      divl_q <= sh_rdata;
    end else if (req.wr && req.addr == `SWL_OFS_DIVLO && div_wr_ok) begin
      divl_q <= req.wdata;
    end
  end

  // One lock for the pair: either byte's first normal write closes both
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_lock_q <= 1'b0;
    end else if (req.wr && special_mode_n && !loading && load_done &&
                 (req.addr == `SWL_OFS_DIVHI || req.addr == `SWL_OFS_DIVLO)) begin
      div_lock_q <= 1'b1;
    end
  end

  // Done flag rises at the same edge that captures the low byte
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      load_done <= 1'b0;
    end else if (ld_q == SWL_LD_DONE) begin
      load_done <= 1'b1;
    end
  end

  // ****************************************************************
  // Array address and register read port
  // ****************************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aaddr_q <= 12'h000;
    end else if (req.wr && req.addr == `SWL_OFS_ARRADDR) begin
      aaddr_q <= {aaddr_q[11:8], req.wdata};
    end else if (req.wr && req.addr == 4'h7) begin
      aaddr_q <= {req.wdata[3:0], aaddr_q[7:0]};
    end
  end

  // Memory reads are already registered, so select them in the data cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_arr_q    <= 1'b0;
      rdata_reg_q <= 8'h00;
    end else begin
      rd_arr_q <= req.rd && req.addr == `SWL_OFS_ARRDATA;
      unique case (req.addr)
        `SWL_OFS_MODCFG:  rdata_reg_q <= cfg_q;
        `SWL_OFS_BLKPROT: rdata_reg_q <= prot_q;
        `SWL_OFS_DIVHI:   rdata_reg_q <= divh_q;
        `SWL_OFS_DIVLO:   rdata_reg_q <= divl_q;
        `SWL_OFS_ARRADDR: rdata_reg_q <= aaddr_q[7:0];
        `SWL_OFS_STATUS:  rdata_reg_q <= {6'h00, div_lock_q, load_done};
        4'h7:             rdata_reg_q <= {4'h0, aaddr_q[11:8]};
        default:          rdata_reg_q <= 8'h00;
      endcase
    end
  end

  // Shadow decode selects which memory answers an array read
  logic hit_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hits_shadow;
    end
  end

  always_comb begin
    if (rd_arr_q) begin
      reg_rdata = hit_q ? sh_rdata : ar_rdata;
    end else begin
      reg_rdata = rdata_reg_q;
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  // Straight from the registers, so a taken write shows at the same edge
  assign shadow_hide           = cfg_q[`SWL_CFG_HIDE];
  assign debug_lockout_disable = cfg_q[`SWL_CFG_DBGLOCK];
  assign prog_divider          = {divh_q, divl_q};

endmodule
`default_nettype wire

// ===== bench/swl_loader_props.sv
// Concurrent checks on the shadow word loader ports
`timescale 1ns/1ps
`default_nettype none
`include "swl_consts.svh"

module swl_loader_props
  import swl_pkg::*;
(
  input wire logic        clock,                 // System clock
  input wire logic        sys_rst,               // Async reset, active high
  input wire logic        special_mode_n,        // Low in special mode
  input wire logic [3:0]  reg_addr,              // Register address
  input wire logic [7:0]  reg_wdata,             // Write data
  input wire logic        reg_wr,                // Write strobe
  input wire logic        reg_rd,                // Read strobe
  input wire logic [7:0]  reg_rdata,             // Read data
  input wire logic        load_done,             // Reset load finished
  input wire logic        shadow_hide,           // Shadow word hidden
  input wire logic        debug_lockout_disable, // Debug lockout off
  input wire logic [15:0] prog_divider           // Divider high:low
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic div_wr;
  logic div_ok;
  logic cfg_wr;
  logic lock_q;

  // Own copy of the write-once lock, so a stuck lock in the design shows up
  assign div_wr = load_done && reg_wr && (reg_addr == `SWL_OFS_DIVHI || reg_addr == `SWL_OFS_DIVLO);
  assign div_ok = div_wr && (!special_mode_n || !lock_q);
  assign cfg_wr = load_done && reg_wr && !special_mode_n && reg_addr == `SWL_OFS_MODCFG;

  // Lock flag, cleared by reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lock_q <= 1'b0;
    end else if (div_wr && special_mode_n) begin
      lock_q <= 1'b1;
    end
  end

  property p_load_time; $fell(sys_rst) |-> !load_done [*3] ##1 load_done; endproperty
  a_load_time: assert property (p_load_time) else $error("load not done on third edge");
  property p_load_mask; $rose(load_done) |-> prog_divider[15:10] == 6'h00; endproperty
  a_load_mask: assert property (p_load_mask) else $error("divider high loaded with spare bits");
  property p_div_hold; load_done && !div_ok |=> $stable(prog_divider); endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider changed without accepted write");
  property p_divlo_wr; div_ok && reg_addr == `SWL_OFS_DIVLO |=> prog_divider[7:0] == $past(reg_wdata); endproperty
  a_divlo_wr: assert property (p_divlo_wr) else $error("divider low write lost");
  property p_divhi_wr;
    div_ok && reg_addr == `SWL_OFS_DIVHI |=> prog_divider[15:8] == ($past(reg_wdata) & `SWL_DIVH_MASK);
  endproperty
  a_divhi_wr: assert property (p_divhi_wr) else $error("divider high write lost");
  property p_cfg_hold; load_done && !cfg_wr |=> $stable({debug_lockout_disable, shadow_hide}); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config bits changed without special write");
  property p_cfg_wr; cfg_wr |=> {debug_lockout_disable, shadow_hide} == $past(reg_wdata[7:6]); endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("special config write lost");
  property p_cfg_rd;
    load_done && reg_rd && reg_addr == `SWL_OFS_MODCFG |=> reg_rdata[7:6] == {debug_lockout_disable, shadow_hide};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read disagrees with outputs");
  property p_divlo_rd; load_done && reg_rd && reg_addr == `SWL_OFS_DIVLO |=> reg_rdata == prog_divider[7:0]; endproperty
  a_divlo_rd: assert property (p_divlo_rd) else $error("divider low read disagrees");

  c_lock: cover property (div_wr && special_mode_n && lock_q);
  c_cfg: cover property (cfg_wr);
  c_load: cover property ($rose(load_done));
endmodule

bind swl_loader swl_loader_props swl_loader_props_inst (.clock, .sys_rst, .special_mode_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .load_done, .shadow_hide, .debug_lockout_disable, .prog_divider);
`default_nettype wire

// ===== bench/swl_cpu_model.sv
// Software side of the register port: one-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none

module swl_cpu_model (
  input  wire logic       clock,     // System clock
  input  wire logic [7:0] reg_rdata, // Read data from the loader
  output var logic  [3:0] reg_addr,  // Register address
  output var logic  [7:0] reg_wdata, // Write data
  output var logic        reg_wr,    // Write strobe
  output var logic        reg_rd     // Read strobe
);
  // Idle bus at time zero
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write cycle; the #1 lets the taking edge's updates land
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  // One read cycle; data only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Directed bench for the shadow word loader
`timescale 1ns/1ps
`default_nettype none
`include "swl_consts.svh"

module tb_top;
  logic        clock;
  logic        sys_rst;
  logic        special_mode_n;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        load_done;
  logic        shadow_hide;
  logic        debug_lockout_disable;
  logic [15:0] prog_divider;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycle_count = 0;

  swl_loader swl_loader_inst (.clock, .sys_rst, .special_mode_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .load_done, .shadow_hide, .debug_lockout_disable, .prog_divider);
  swl_cpu_model swl_cpu_model_inst (.clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Run far shorter than this; a hang lands here
  always @(posedge clock) begin
    cycle_count++;
    if (cycle_count == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    swl_cpu_model_inst.rd(a, d);
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask

  // Reset for 4 cycles; load needs 3 edges after release
  task automatic do_reset(input logic mode_n);
    @(posedge clock);
    sys_rst <= 1'b1;
    special_mode_n <= mode_n;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("load_done", 16'h0001, {15'h0, load_done});
  endtask

  initial begin
    sys_rst = 1'b1;
    special_mode_n = 1'b1;
    do_reset(1'b1);
    chk("divider", 16'h03ff, prog_divider);
    chk("flags", 16'h0003, {14'h0, debug_lockout_disable, shadow_hide});
    rchk(`SWL_OFS_MODCFG, 8'hfc, "config");
    rchk(`SWL_OFS_STATUS, 8'h01, "status");
    rchk(4'hf, 8'h00, "unmapped");
    $display("test blank load finished");
    swl_cpu_model_inst.wr(`SWL_OFS_DIVHI, 8'hfe);
    swl_cpu_model_inst.wr(`SWL_OFS_DIVLO, 8'h30);
    swl_cpu_model_inst.wr(`SWL_OFS_MODCFG, 8'h0c);
    chk("divider", 16'h02ff, prog_divider);
    chk("hide", 16'h0001, {15'h0, shadow_hide});
    rchk(`SWL_OFS_STATUS, 8'h03, "status");
    $display("test normal lock finished");
    do_reset(1'b0);
    rchk(`SWL_OFS_STATUS, 8'h01, "status");
    swl_cpu_model_inst.wr(4'h7, 8'h0f);
    swl_cpu_model_inst.wr(`SWL_OFS_ARRADDR, 8'hc0);
    swl_cpu_model_inst.wr(`SWL_OFS_ARRDATA, 8'h5a);
    rchk(`SWL_OFS_ARRDATA, 8'h5a, "array byte");
    swl_cpu_model_inst.wr(`SWL_OFS_DIVHI, 8'h02);
    swl_cpu_model_inst.wr(`SWL_OFS_DIVLO, 8'h30);
    swl_cpu_model_inst.wr(`SWL_OFS_BLKPROT, 8'h7f);
    swl_cpu_model_inst.wr(`SWL_OFS_MODCFG, 8'hbc);
    chk("hide", 16'h0000, {15'h0, shadow_hide});
    rchk(`SWL_OFS_ARRDATA, 8'hff, "shadow high");
    swl_cpu_model_inst.wr(`SWL_OFS_ARRDATA, 8'hfe);
    swl_cpu_model_inst.wr(`SWL_OFS_ARRADDR, 8'hc1);
    swl_cpu_model_inst.wr(`SWL_OFS_ARRDATA, 8'h30);
    rchk(`SWL_OFS_ARRDATA, 8'h30, "shadow low");
    swl_cpu_model_inst.wr(`SWL_OFS_BLKPROT, 8'hff);
    swl_cpu_model_inst.wr(`SWL_OFS_ARRDATA, 8'h00);
    rchk(`SWL_OFS_ARRDATA, 8'h30, "protected shadow");
    swl_cpu_model_inst.wr(`SWL_OFS_DIVLO, 8'h11);
    chk("divider", 16'h0211, prog_divider);
    $display("test special preset finished");
    do_reset(1'b1);
    chk("divider", 16'h0230, prog_divider);
    chk("flags", 16'h0003, {14'h0, debug_lockout_disable, shadow_hide});
    swl_cpu_model_inst.wr(`SWL_OFS_DIVLO, 8'h12);
    swl_cpu_model_inst.wr(`SWL_OFS_DIVHI, 8'h01);
    chk("divider", 16'h0212, prog_divider);
    swl_cpu_model_inst.wr(4'h7, 8'h0f);
    swl_cpu_model_inst.wr(`SWL_OFS_ARRADDR, 8'hc0);
    rchk(`SWL_OFS_ARRDATA, 8'h5a, "hidden array byte");
    $display("test reload finished");
    report_and_stop();
  end
endmodule
`default_nettype wire
